// >>> pkg/qog_consts.vh
// Register indices, field positions, reset values and constants of the offset and gain block.
`ifndef QOG_CONSTS_VH
`define QOG_CONSTS_VH

// Register indices; the byte address on the bus is four times the index.
`define QOG_IDX_C_OFFSET      8'h0A
`define QOG_IDX_D_OFFSET      8'h0B
`define QOG_IDX_A_GAIN        8'h0C
`define QOG_IDX_B_GAIN_MIX    8'h0D
`define QOG_IDX_C_GAIN        8'h0E
`define QOG_IDX_AUTO_SYNC     8'h1E
`define QOG_IDX_ACTIVE_OFFSET 8'h1F

// Field layout.
`define QOG_OFFSET_MSB        12
`define QOG_GAIN_MSB          10
`define QOG_MIX_MSB           15
`define QOG_MIX_LSB           12
`define QOG_MIX_FS8_BIT       3
`define QOG_MIX_FS4_BIT       2
`define QOG_MIX_FS2_BIT       1
`define QOG_MIX_NFS4_BIT      0
`define QOG_AUTO_SYNC_BIT     0
`define QOG_ACT_D_LSB         16

// Reset values.
`define QOG_OFFSET_RST        13'h0000
`define QOG_GAIN_RST          11'h400
`define QOG_MIX_RST           4'h0
`define QOG_AUTO_SYNC_RST     1'b1

// Mixer phase steps in eighths of a turn per sample.
`define QOG_STEP_FS8          3'h1
`define QOG_STEP_FS4          3'h2
`define QOG_STEP_FS2          3'h4
`define QOG_STEP_NFS4         3'h6

// Cosine of 45 degrees in the same 10-bit fraction as the gain words.
`define QOG_COS45             18'h002D4
`define QOG_FRAC_BITS         10

`endif

// >>> core/qog_regs.v
// Offset, gain and coarse mixer registers with the sample correction path.
//
// Chosen here: register access over APB.
`timescale 1ns/10ps
`include "qog_consts.vh"

// Behaviour
// - Channel C offset is 13 bits in converter LSBs, reset zero.
// - Channel D offset is 13 bits in converter LSBs, reset zero.
// - With auto-sync on, writing C offset loads C and D offsets together.
// - Writing D offset alone leaves the active offset unchanged until C written with auto-sync on, or a sync pulse.
// - Gain words are unsigned 11 bits, binary point between bits 9 and 10.
// - Channel A samples are scaled by the channel A gain word.
// - Channel B samples are scaled by the gain word sharing the mixer register.
// - Channel C samples are scaled by the channel C gain word.
// - Four mixer bits select Fs/8, Fs/4, Fs/2 and -Fs/4; reset 0000.
// - Several mixers may be on together, giving n eighths of Fs in total.
module qog_regs
#(
  parameter SAMPLE_W = 16
)
(
  input  wire                pclk,
  input  wire                presetn,
  input  wire                psel,
  input  wire                penable,
  input  wire                pwrite,
  input  wire [11:0]         paddr,
  input  wire [31:0]         pwdata,
  output wire [31:0]         prdata,
  output wire                pready,
  output wire                pslverr,
  input  wire                sync_pulse,
  input  wire                sample_valid,
  input  wire [SAMPLE_W-1:0] channel_a_in,
  input  wire [SAMPLE_W-1:0] channel_b_in,
  input  wire [SAMPLE_W-1:0] channel_c_in,
  input  wire [SAMPLE_W-1:0] channel_d_in,
  output wire                out_valid,
  output wire [SAMPLE_W-1:0] channel_a_out,
  output wire [SAMPLE_W-1:0] channel_b_out,
  output wire [SAMPLE_W-1:0] channel_c_out,
  output wire [SAMPLE_W-1:0] channel_d_out
);

  ////////////////////////////////////////////////////////////////////////////////////////
  // Helper functions.
  // Clamps a wide signed value to the sample range.
  function [SAMPLE_W-1:0] qog_sat;
    input signed [18:0] val;
    reg signed [18:0] lim_hi;
    reg signed [18:0] lim_lo;
    begin
      lim_hi = (19'sd1 <<< (SAMPLE_W - 1)) - 19'sd1;
      lim_lo = -(19'sd1 <<< (SAMPLE_W - 1));
      if (val > lim_hi)
        qog_sat = lim_hi[SAMPLE_W-1:0];
      else if (val < lim_lo)
        qog_sat = lim_lo[SAMPLE_W-1:0];
      else
        qog_sat = val[SAMPLE_W-1:0];
    end
  endfunction

  // Scales a sample by an unsigned 1.10 gain word, then adds the offset.
  function [SAMPLE_W-1:0] qog_scale;
    input [SAMPLE_W-1:0] smp;
    input [10:0]         gain;
    input [12:0]         offs;
    reg signed [27:0] prod;
    reg signed [18:0] sum;
    begin
      prod = $signed(smp) * $signed({1'b0, gain});
      sum  = $signed({prod[27], prod[27:`QOG_FRAC_BITS]})
             + $signed({{6{offs[12]}}, offs});
      qog_scale = qog_sat(sum);
    end
  endfunction

  // Rotates an I/Q pair by a whole number of eighths of a turn.
  function [2*SAMPLE_W-1:0] qog_rotate;
    input [SAMPLE_W-1:0] i_in;
    input [SAMPLE_W-1:0] q_in;
    input [2:0]          ph;
    reg signed [17:0] i1;
    reg signed [17:0] q1;
    reg signed [27:0] pi;
    reg signed [27:0] pq;
    reg signed [17:0] i2;
    reg signed [17:0] q2;
    begin
      i1 = $signed({{(18-SAMPLE_W){i_in[SAMPLE_W-1]}}, i_in});
      q1 = $signed({{(18-SAMPLE_W){q_in[SAMPLE_W-1]}}, q_in});
      if (ph[0])
      begin
        pi = (i1 - q1) * $signed(`QOG_COS45);
        pq = (i1 + q1) * $signed(`QOG_COS45);
        i1 = pi[27:`QOG_FRAC_BITS];
        q1 = pq[27:`QOG_FRAC_BITS];
      end
      case (ph[2:1])
        2'd0:
        begin
          i2 = i1;
          q2 = q1;
        end
        2'd1:
        begin
          i2 = -q1;
          q2 = i1;
        end
        2'd2:
        begin
          i2 = -i1;
          q2 = -q1;
        end
        default:
        begin
          i2 = q1;
          q2 = -i1;
        end
      endcase
      qog_rotate = {qog_sat({q2[17], q2}), qog_sat({i2[17], i2})};
    end
  endfunction

  // Decodes a byte address to a register index; misaligned or out of range gives 8'hFF.
  function [7:0] qog_index;
    input [11:0] addr;
    begin
      if (addr[1:0] != 2'b00 || addr[11:10] != 2'b00)
        qog_index = 8'hFF;
      else
        qog_index = addr[9:2];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////////////
  // Register bus.
  reg  [12:0] c_offset_reg;
  reg  [12:0] d_offset_reg;
  reg  [10:0] a_gain_reg;
  reg  [10:0] b_gain_reg;
  reg  [3:0]  mix_reg;
  reg  [10:0] c_gain_reg;
  reg         auto_sync_reg;
  reg  [12:0] c_offset_act_reg;
  reg  [12:0] d_offset_act_reg;
  reg  [31:0] rdata_reg;
  reg  [31:0] rdata_next;
  reg         hit_next;
  reg         hit_reg;

  wire [7:0]  idx       = qog_index(paddr);
  wire        setup_ph  = psel & ~penable;
  wire        access_ph = psel & penable;
  wire        wr_en     = access_ph & pwrite & hit_reg;
  assign pready  = 1'b1;
  assign pslverr = access_ph & ~hit_reg;
  assign prdata  = rdata_reg;
  // Read data is captured in the setup cycle so prdata comes from a flop.
  // Reserved bits are not stored and read back as zero.
  always @*
  begin
    rdata_next = 32'h0000_0000;
    hit_next   = 1'b1;
    case (idx)
      `QOG_IDX_C_OFFSET:      rdata_next[12:0] = c_offset_reg;
      `QOG_IDX_D_OFFSET:      rdata_next[12:0] = d_offset_reg;
      `QOG_IDX_A_GAIN:        rdata_next[10:0] = a_gain_reg;
      `QOG_IDX_B_GAIN_MIX:    rdata_next[15:0] = {mix_reg, 1'b0, b_gain_reg};
      `QOG_IDX_C_GAIN:        rdata_next[10:0] = c_gain_reg;
      `QOG_IDX_AUTO_SYNC:     rdata_next[`QOG_AUTO_SYNC_BIT] = auto_sync_reg;
      `QOG_IDX_ACTIVE_OFFSET:
      begin
        rdata_next[12:0]  = c_offset_act_reg;
        rdata_next[28:16] = d_offset_act_reg;
      end
      default:                hit_next = 1'b0;
    endcase
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rdata_reg <= 32'h0000_0000;
      hit_reg   <= 1'b0;
    end
    else if (setup_ph)
    begin
      rdata_reg <= pwrite ? 32'h0000_0000 : rdata_next;
      hit_reg   <= hit_next;
    end
  end

  // Only the documented field bits are stored; reserved write bits are dropped.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      c_offset_reg  <= `QOG_OFFSET_RST;
      d_offset_reg  <= `QOG_OFFSET_RST;
      a_gain_reg    <= `QOG_GAIN_RST;
      b_gain_reg    <= `QOG_GAIN_RST;
      mix_reg       <= `QOG_MIX_RST;
      c_gain_reg    <= `QOG_GAIN_RST;
      auto_sync_reg <= `QOG_AUTO_SYNC_RST;
    end
    else if (wr_en)
    begin
      case (idx)
        `QOG_IDX_C_OFFSET:   c_offset_reg  <= pwdata[`QOG_OFFSET_MSB:0];
        `QOG_IDX_D_OFFSET:   d_offset_reg  <= pwdata[`QOG_OFFSET_MSB:0];
        `QOG_IDX_A_GAIN:     a_gain_reg    <= pwdata[`QOG_GAIN_MSB:0];
        `QOG_IDX_B_GAIN_MIX:
        begin
          b_gain_reg <= pwdata[`QOG_GAIN_MSB:0];
          mix_reg    <= pwdata[`QOG_MIX_MSB:`QOG_MIX_LSB];
        end
        `QOG_IDX_C_GAIN:     c_gain_reg    <= pwdata[`QOG_GAIN_MSB:0];
        `QOG_IDX_AUTO_SYNC:  auto_sync_reg <= pwdata[`QOG_AUTO_SYNC_BIT];
        default:             auto_sync_reg <= auto_sync_reg;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////
  // Active offsets.
  // The C write carries its new value straight in, so both halves land on the same edge.
  // The held D value is used, which is why D must be written before C.
  wire c_write   = wr_en && (idx == `QOG_IDX_C_OFFSET);
  wire auto_load = c_write & auto_sync_reg;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      c_offset_act_reg <= `QOG_OFFSET_RST;
      d_offset_act_reg <= `QOG_OFFSET_RST;
    end
    else if (auto_load)
    begin
      c_offset_act_reg <= pwdata[`QOG_OFFSET_MSB:0];
      d_offset_act_reg <= d_offset_reg;
    end
    else if (sync_pulse)
    begin
      c_offset_act_reg <= c_offset_reg;
      d_offset_act_reg <= d_offset_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////
  // Sample path: gain and offset, then coarse mixing.
  // Channel D has no gain control in this block and passes at unity gain.
  reg  [SAMPLE_W-1:0] a_scaled_reg;
  reg  [SAMPLE_W-1:0] b_scaled_reg;
  reg  [SAMPLE_W-1:0] c_scaled_reg;
  reg  [SAMPLE_W-1:0] d_scaled_reg;
  reg                 scaled_valid_reg;
  reg  [SAMPLE_W-1:0] a_out_reg;
  reg  [SAMPLE_W-1:0] b_out_reg;
  reg  [SAMPLE_W-1:0] c_out_reg;
  reg  [SAMPLE_W-1:0] d_out_reg;
  reg                 out_valid_reg;
  reg  [2:0]          phase_reg;
  reg  [2:0]          step_next;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      a_scaled_reg     <= {SAMPLE_W{1'b0}};
      b_scaled_reg     <= {SAMPLE_W{1'b0}};
      c_scaled_reg     <= {SAMPLE_W{1'b0}};
      d_scaled_reg     <= {SAMPLE_W{1'b0}};
      scaled_valid_reg <= 1'b0;
    end
    else
    begin
      scaled_valid_reg <= sample_valid;
      if (sample_valid)
      begin
        a_scaled_reg <= qog_scale(channel_a_in, a_gain_reg, 13'h0000);
        b_scaled_reg <= qog_scale(channel_b_in, b_gain_reg, 13'h0000);
        c_scaled_reg <= qog_scale(channel_c_in, c_gain_reg, c_offset_act_reg);
        d_scaled_reg <= qog_scale(channel_d_in, `QOG_GAIN_RST,
                                  d_offset_act_reg);
      end
    end
  end

  // Each enabled mixer adds its own step; the sum wraps in eighths of a turn.
  always @*
  begin
    step_next = 3'h0;
    if (mix_reg[`QOG_MIX_FS8_BIT])
      step_next = step_next + `QOG_STEP_FS8;
    if (mix_reg[`QOG_MIX_FS4_BIT])
      step_next = step_next + `QOG_STEP_FS4;
    if (mix_reg[`QOG_MIX_FS2_BIT])
      step_next = step_next + `QOG_STEP_FS2;
    if (mix_reg[`QOG_MIX_NFS4_BIT])
      step_next = step_next + `QOG_STEP_NFS4;
  end

  // A and B form one complex pair, C and D the other; both share one phase.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      phase_reg     <= 3'h0;
      a_out_reg     <= {SAMPLE_W{1'b0}};
      b_out_reg     <= {SAMPLE_W{1'b0}};
      c_out_reg     <= {SAMPLE_W{1'b0}};
      d_out_reg     <= {SAMPLE_W{1'b0}};
      out_valid_reg <= 1'b0;
    end
    else
    begin
      out_valid_reg <= scaled_valid_reg;
      if (scaled_valid_reg)
      begin
        phase_reg              <= phase_reg + step_next;
        {b_out_reg, a_out_reg} <= qog_rotate(a_scaled_reg, b_scaled_reg, phase_reg);
        {d_out_reg, c_out_reg} <= qog_rotate(c_scaled_reg, d_scaled_reg, phase_reg);
      end
    end
  end

  assign out_valid     = out_valid_reg;
  assign channel_a_out = a_out_reg;
  assign channel_b_out = b_out_reg;
  assign channel_c_out = c_out_reg;
  assign channel_d_out = d_out_reg;

endmodule

// >>> dv/qog_sample_src.sv
// Upstream sample source feeding the four channel inputs.
`timescale 1ns/10ps
module qog_sample_src (
  input  logic        pclk,
  output logic        sample_valid,
  output logic [15:0] channel_a_in,
  output logic [15:0] channel_b_in,
  output logic [15:0] channel_c_in,
  output logic [15:0] channel_d_in
);
  initial
  begin
    sample_valid = 1'b0;
    {channel_a_in, channel_b_in, channel_c_in, channel_d_in} = 64'h0;
  end

  // Data is inverted once taken, so a design that samples late sees garbage.
  task send(input logic [63:0] s);
    begin
      @(posedge pclk);
      sample_valid <= 1'b1;
      {channel_a_in, channel_b_in, channel_c_in, channel_d_in} <= s;
      @(posedge pclk);
      sample_valid <= 1'b0;
      {channel_a_in, channel_b_in, channel_c_in, channel_d_in} <= ~s;
    end
  endtask
endmodule

// >>> dv/qog_regs_assertions.sv
// Concurrent checks on the bus and sample ports of the offset and gain block.
`timescale 1ns/10ps
module qog_chk (
  input logic        pclk,
  input logic        presetn,
  input logic        psel,
  input logic        penable,
  input logic [11:0] paddr,
  input logic [31:0] prdata,
  input logic        pready,
  input logic        pslverr,
  input logic        sample_valid,
  input logic        out_valid
);
  wire acc = psel && penable;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////////////////
  property p_lat; sample_valid |-> ##2 out_valid; endproperty
  a_lat: assert property (p_lat) else $error("sample lost");
  property p_only; out_valid |-> $past(sample_valid, 2); endproperty
  a_only: assert property (p_only) else $error("spurious output");
  property p_c_off; acc && paddr == 12'h028 |-> pready && !pslverr; endproperty
  a_c_off: assert property (p_c_off) else $error("C offset refused");
  property p_d_off; acc && paddr == 12'h02C |-> pready && !pslverr; endproperty
  a_d_off: assert property (p_d_off) else $error("D offset refused");
  property p_a_gain; acc && paddr == 12'h030 |-> !pslverr; endproperty
  a_a_gain: assert property (p_a_gain) else $error("A gain refused");
  property p_b_gain; acc && paddr == 12'h034 |-> !pslverr; endproperty
  a_b_gain: assert property (p_b_gain) else $error("B gain refused");
  property p_c_gain; acc && paddr == 12'h038 |-> !pslverr; endproperty
  a_c_gain: assert property (p_c_gain) else $error("C gain refused");
  property p_unmap; acc && paddr[11:10] != 2'h0 |-> pslverr && prdata == 32'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped accepted");
endmodule

bind qog_regs qog_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .sample_valid(sample_valid), .out_valid(out_valid));

// >>> dv/tb_quad_dac_qmc_offset_gain_regs.sv
// Self-checking bench for the offset, gain and coarse mixer block.
`timescale 1ns/10ps
module tb_quad_dac_qmc_offset_gain_regs;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic        sync_pulse, sample_valid, out_valid;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, o0, o1, cd;
  logic [15:0] ai, bi, ci, di, ao, bo, co;
  logic [15:0] do_o;
  int          err_count, checks, i;
  logic [15:0] modes [0:4] = '{16'h2000, 16'h4000, 16'h1000, 16'h8000, 16'h5000};
  int          steps [0:4] = '{1, 2, 2, 4, 1};
  logic [11:0] ad [0:5] = '{12'h028, 12'h02C, 12'h030, 12'h034, 12'h038, 12'h078};
  logic [31:0] ex [0:5] = '{32'h0, 32'h0, 32'h400, 32'h400, 32'h400, 32'h1};
  localparam logic [63:0] S = 64'h1000_1000_1000_1000;

  qog_sample_src src (.pclk(pclk), .sample_valid(sample_valid), .channel_a_in(ai),
    .channel_b_in(bi), .channel_c_in(ci), .channel_d_in(di));
  qog_regs #(.SAMPLE_W(16)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sync_pulse(sync_pulse), .sample_valid(sample_valid),
    .channel_a_in(ai), .channel_b_in(bi), .channel_c_in(ci), .channel_d_in(di),
    .out_valid(out_valid), .channel_a_out(ao), .channel_b_out(bo), .channel_c_out(co),
    .channel_d_out(do_o));
  ////////////////////////////////////////////////////////////////////////////
  task stop_test;
    begin
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    begin
      checks++;
      if (got !== exp)
      begin
        err_count++;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    begin
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // No wait-state limit here: a slave that never answers is caught by the watchdog.
      do
        @(posedge pclk);
      while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task smp(input logic [63:0] s, output logic [31:0] ab, output logic [31:0] cdo);
    int n;
    begin
      src.send(s);
      n = 0;
      do
      begin
        @(posedge pclk);
        #1;
        n++;
      end
      while (out_valid !== 1'b1 && n < 8);
      chk({31'h0, out_valid}, 32'h1);
      ab = {ao, bo};
      cdo = {co, do_o};
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task t_reset;
    begin
      for (i = 0; i < 6; i++)
      begin
        apb(1'b0, ad[i], 32'h0);
        chk(rd, ex[i]);
      end
      $display("test reset done");
    end
  endtask

  task t_offset;
    begin
      apb(1'b1, 12'h02C, 32'h0155);
      apb(1'b0, 12'h07C, 32'h0);
      chk(rd, 32'h0);
      apb(1'b1, 12'h028, 32'h0AAA);
      apb(1'b0, 12'h07C, 32'h0);
      chk(rd, 32'h0155_0AAA);
      $display("test offset done");
    end
  endtask

  // Gains are picked so every product is exact and no rounding hides a slip.
  task t_gain;
    begin
      apb(1'b1, 12'h030, 32'h200);
      apb(1'b1, 12'h034, 32'h600);
      apb(1'b1, 12'h038, 32'h7FF);
      smp(S, o0, cd);
      chk(o0, 32'h0800_1800);
      chk(cd, 32'h2AA6_1155);
      $display("test gain done");
    end
  endtask

  task t_mix;
    begin
      for (i = 0; i < 5; i++)
      begin
        apb(1'b1, 12'h034, {16'h0, modes[i] | 16'h0600});
        smp(S, o0, cd);
        repeat (steps[i]) smp(S, o1, cd);
        chk(o1, (i == 4) ? o0 : {-o0[31:16], -o0[15:0]});
      end
      $display("test mixer done");
    end
  endtask

  task t_sync;
    begin
      apb(1'b1, 12'h078, 32'h0);
      apb(1'b1, 12'h028, 32'h0123);
      apb(1'b0, 12'h07C, 32'h0);
      chk(rd, 32'h0155_0AAA);
      @(posedge pclk);
      sync_pulse <= 1'b1;
      @(posedge pclk);
      sync_pulse <= 1'b0;
      apb(1'b0, 12'h07C, 32'h0);
      chk(rd, 32'h0155_0123);
      apb(1'b0, 12'h400, 32'h0);
      chk({rd[30:0], er}, 32'h1);
      $display("test sync done");
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  initial
  begin
    #400000;
    err_count++;
    stop_test;
  end

  initial
  begin
    {presetn, psel, penable, pwrite, sync_pulse, paddr, pwdata} = '0;
    err_count = 0;
    checks = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_offset;
    t_gain;
    t_mix;
    t_sync;
    stop_test;
  end
endmodule
